/* File: hw/chsf_top.sv */
// Card host interface: status flags, command and data line engine, APB registers.
// Assumes card_clk and dat0 come from the card side, unsynchronised.
// Overview of operation
// - Command-sent low during command, cleared by write
// - Receive-ready set on data, cleared by read
// - Transmit-moved set on shift load, cleared by write
// - Block-end set per write CRC token, read-cleared
// - Transfer-active held until CRC16 finishes
//
// Decided for this implementation: the APB interface to the registers.
`default_nettype none
module chsf_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic card_clk,
  output logic cmd_o,
  output logic cmd_oe,
  input wire logic dat0_i,
  output logic dat0_o,
  output logic dat0_oe
);
  // Pin synchronisation and link clock edges
  logic clk_s;
  logic dat0_s;
  logic clk_prev_q;
  logic lk_rise;
  logic lk_fall;

  chsf_sync #(.W(2)) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d({card_clk, dat0_i}),
    .q({clk_s, dat0_s})
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_prev_q <= 1'b1;
    end else begin
      clk_prev_q <= clk_s;
    end
  end

  assign lk_rise = clk_s & ~clk_prev_q;
  assign lk_fall = ~clk_s & clk_prev_q;

  // APB decode
  logic setup;
  logic access;
  logic wr;
  logic rd;
  logic hit_ctrl;
  logic hit_cmd;
  logic hit_rx;
  logic hit_tx;
  logic hit_st;
  logic hit_ist;
  logic hit_imask;
  logic mapped;

  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign wr = access & pwrite;
  assign rd = access & ~pwrite;
  assign hit_ctrl = paddr == chsf_pkg::ADDR_CTRL;
  assign hit_cmd = paddr == chsf_pkg::ADDR_COMMAND;
  assign hit_rx = paddr == chsf_pkg::ADDR_RECEIVE;
  assign hit_tx = paddr == chsf_pkg::ADDR_TRANSMIT;
  assign hit_st = paddr == chsf_pkg::ADDR_STATUS;
  assign hit_ist = paddr == chsf_pkg::ADDR_IRQ_STAT;
  assign hit_imask = paddr == chsf_pkg::ADDR_IRQ_MASK;
  assign mapped = hit_ctrl | hit_cmd | hit_rx | hit_tx | hit_st | hit_ist | hit_imask;
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  logic wr_cmd;
  logic wr_tx;
  logic wr_ctrl;
  logic rd_rx;
  logic rd_st;

  assign wr_cmd = wr & hit_cmd;
  assign wr_tx = wr & hit_tx;
  assign wr_ctrl = wr & hit_ctrl;
  assign rd_rx = rd & hit_rx;
  assign rd_st = rd & hit_st;

  // Command line shifter
  logic [31:0] cmd_sr_q;
  logic [5:0] cmd_cnt_q;
  logic cmd_busy_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_sr_q <= 32'h0000_0000;
      cmd_cnt_q <= 6'h00;
      cmd_busy_q <= ~chsf_pkg::RST_CMD_SENT;
      cmd_o <= 1'b1;
      cmd_oe <= 1'b0;
    end else if (wr_cmd) begin
      cmd_sr_q <= pwdata;
      cmd_cnt_q <= chsf_pkg::CMD_BITS;
      cmd_busy_q <= 1'b1;
    end else if (cmd_busy_q && lk_fall) begin
      if (cmd_cnt_q != 6'h00) begin
        cmd_o <= cmd_sr_q[31];
        cmd_oe <= 1'b1;
        cmd_sr_q <= {cmd_sr_q[30:0], 1'b0};
        cmd_cnt_q <= cmd_cnt_q - 6'h01;
      end else begin
        cmd_busy_q <= 1'b0;
        cmd_oe <= 1'b0;
        cmd_o <= 1'b1;
      end
    end
  end

  // Data line engine
  chsf_pkg::chsf_state_t state_q;
  logic [31:0] sh_q;
  logic [31:0] tx_hold_q;
  logic [31:0] rx_data_q;
  logic [4:0] bit_cnt_q;
  logic [3:0] word_cnt_q;
  logic [3:0] crc_cnt_q;
  logic xfer_act_q;
  logic crc_clr;
  logic crc_en;
  logic crc_bit;
  logic [15:0] crc_q;
  logic start_req;
  logic tx_load;
  logic rx_word;
  logic tok_done;
  logic crc_bad;
  logic [31:0] tx_src;

  assign start_req = wr_ctrl & pwdata[chsf_pkg::CTRL_START] & (state_q == chsf_pkg::CHSF_IDLE);
  // A word written in the same cycle as a load goes straight to the shifter
  assign tx_src = wr_tx ? pwdata : tx_hold_q;
  assign tx_load = lk_fall & ((state_q == chsf_pkg::CHSF_TX_START) |
                   ((state_q == chsf_pkg::CHSF_TX_DATA) & (bit_cnt_q == 5'h00) &
                    (word_cnt_q != 4'h0)));
  assign rx_word = lk_rise & (state_q == chsf_pkg::CHSF_RX_DATA) & (bit_cnt_q == 5'h00);
  assign tok_done = lk_rise & (state_q == chsf_pkg::CHSF_TOK_BITS) &
                    (bit_cnt_q == 5'h01);
  assign crc_bad = (state_q == chsf_pkg::CHSF_RX_CHECK) & (crc_q != 16'h0000);
  assign crc_clr = start_req;
  assign crc_en = (lk_fall & (state_q == chsf_pkg::CHSF_TX_DATA)) |
                  (lk_rise & ((state_q == chsf_pkg::CHSF_RX_DATA) |
                              (state_q == chsf_pkg::CHSF_RX_CRC)));
  assign crc_bit = (state_q == chsf_pkg::CHSF_TX_DATA) ? sh_q[31] : dat0_s;

  chsf_crc16 u_crc (
    .clk(pclk),
    .rst_n(presetn),
    .clear(crc_clr),
    .en(crc_en),
    .bit_in(crc_bit),
    .crc_q(crc_q)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_hold_q <= 32'h0000_0000;
      rx_data_q <= 32'h0000_0000;
    end else begin
      if (wr_tx) begin
        tx_hold_q <= pwdata;
      end
      if (rx_word) begin
        rx_data_q <= {sh_q[30:0], dat0_s};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= chsf_pkg::CHSF_IDLE;
      sh_q <= 32'h0000_0000;
      bit_cnt_q <= 5'h00;
      word_cnt_q <= 4'h0;
      crc_cnt_q <= 4'h0;
      xfer_act_q <= 1'b0;
      dat0_o <= 1'b1;
      dat0_oe <= 1'b0;
    end else begin
      case (state_q)
        chsf_pkg::CHSF_IDLE: begin
          if (start_req) begin
            xfer_act_q <= 1'b1;
            word_cnt_q <= pwdata[chsf_pkg::CTRL_WORDS_HI:chsf_pkg::CTRL_WORDS_LO];
            state_q <= pwdata[chsf_pkg::CTRL_WRITE] ? chsf_pkg::CHSF_TX_START :
                       chsf_pkg::CHSF_RX_WAIT;
          end
        end
        chsf_pkg::CHSF_TX_START: begin
          if (lk_fall) begin
            dat0_o <= 1'b0;
            dat0_oe <= 1'b1;
            sh_q <= tx_src;
            bit_cnt_q <= chsf_pkg::WORD_LAST_BIT;
            state_q <= chsf_pkg::CHSF_TX_DATA;
          end
        end
        chsf_pkg::CHSF_TX_DATA: begin
          if (lk_fall) begin
            dat0_o <= sh_q[31];
            sh_q <= {sh_q[30:0], 1'b0};
            bit_cnt_q <= bit_cnt_q - 5'h01;
            if (bit_cnt_q == 5'h00) begin
              if (word_cnt_q == 4'h0) begin
                crc_cnt_q <= chsf_pkg::CRC_LAST_BIT;
                state_q <= chsf_pkg::CHSF_TX_CRC;
              end else begin
                sh_q <= tx_src;
                word_cnt_q <= word_cnt_q - 4'h1;
              end
            end
          end
        end
        chsf_pkg::CHSF_TX_CRC: begin
          if (lk_fall) begin
            dat0_o <= crc_q[crc_cnt_q];
            crc_cnt_q <= crc_cnt_q - 4'h1;
            if (crc_cnt_q == 4'h0) begin
              xfer_act_q <= 1'b0;
              bit_cnt_q <= 5'h01;
              state_q <= chsf_pkg::CHSF_TX_END;
            end
          end
        end
        chsf_pkg::CHSF_TX_END: begin
          // End bit stands one full link bit, whatever the last CRC bit was
          if (lk_fall) begin
            if (bit_cnt_q != 5'h00) begin
              dat0_o <= 1'b1;
              bit_cnt_q <= 5'h00;
            end else begin
              dat0_oe <= 1'b0;
              state_q <= chsf_pkg::CHSF_TOK_WAIT;
            end
          end
        end
        chsf_pkg::CHSF_TOK_WAIT: begin
          if (lk_rise && !dat0_s) begin
            bit_cnt_q <= chsf_pkg::TOKEN_BITS;
            state_q <= chsf_pkg::CHSF_TOK_BITS;
          end
        end
        chsf_pkg::CHSF_TOK_BITS: begin
          if (lk_rise) begin
            bit_cnt_q <= bit_cnt_q - 5'h01;
            if (bit_cnt_q == 5'h01) begin
              state_q <= chsf_pkg::CHSF_BUSY;
            end
          end
        end
        chsf_pkg::CHSF_BUSY: begin
          if (lk_rise && dat0_s) begin
            state_q <= chsf_pkg::CHSF_IDLE;
          end
        end
        chsf_pkg::CHSF_RX_WAIT: begin
          if (lk_rise && !dat0_s) begin
            bit_cnt_q <= chsf_pkg::WORD_LAST_BIT;
            state_q <= chsf_pkg::CHSF_RX_DATA;
          end
        end
        chsf_pkg::CHSF_RX_DATA: begin
          if (lk_rise) begin
            sh_q <= {sh_q[30:0], dat0_s};
            bit_cnt_q <= bit_cnt_q - 5'h01;
            if (bit_cnt_q == 5'h00) begin
              word_cnt_q <= word_cnt_q - 4'h1;
              if (word_cnt_q == 4'h0) begin
                crc_cnt_q <= chsf_pkg::CRC_LAST_BIT;
                state_q <= chsf_pkg::CHSF_RX_CRC;
              end
            end
          end
        end
        chsf_pkg::CHSF_RX_CRC: begin
          if (lk_rise) begin
            crc_cnt_q <= crc_cnt_q - 4'h1;
            if (crc_cnt_q == 4'h0) begin
              state_q <= chsf_pkg::CHSF_RX_CHECK;
            end
          end
        end
        chsf_pkg::CHSF_RX_CHECK: begin
          xfer_act_q <= 1'b0;
          state_q <= chsf_pkg::CHSF_IDLE;
        end
        default: begin
          state_q <= chsf_pkg::CHSF_IDLE;
          dat0_oe <= 1'b0;
        end
      endcase
    end
  end

  // Status flags; a hardware set beats a software clear, except for command-sent, where a command write wins over completion
  logic rx_ready_q;
  logic tx_moved_q;
  logic blk_end_q;
  logic crc_err_q;
  logic card_free;
  localparam int ST_W = chsf_pkg::ST_WIDTH;
  logic [ST_W-1:0] status;
  logic [31:0] prdata_q;

  assign card_free = dat0_s | dat0_oe;
  assign status = {crc_err_q, card_free, xfer_act_q, blk_end_q, tx_moved_q, rx_ready_q,
                   ~cmd_busy_q};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_ready_q <= 1'b0;
      tx_moved_q <= chsf_pkg::RST_TX_MOVED;
      blk_end_q <= 1'b0;
      crc_err_q <= 1'b0;
    end else begin
      // Set on word, clear on read
      rx_ready_q <= rx_word | (rx_ready_q & ~rd_rx);
      // Set on load, clear on write
      tx_moved_q <= tx_load | (tx_moved_q & ~wr_tx);
      blk_end_q <= tok_done | (blk_end_q & ~(rd_st & prdata_q[chsf_pkg::ST_BLK_END]));
      crc_err_q <= crc_bad | (crc_err_q & ~(rd_st & prdata_q[chsf_pkg::ST_CRC_ERR]));
    end
  end

  // Interrupt status and mask
  logic [ST_W-1:0] status_prev_q;
  logic [ST_W-1:0] ist_q;
  logic [ST_W-1:0] imask_q;
  logic [ST_W-1:0] ev;
  logic [ST_W-1:0] ist_clr;

  assign ev = (status & ~status_prev_q) |
              {2'b00, status_prev_q[chsf_pkg::ST_XFER_ACT] & ~xfer_act_q, 4'h0};
  assign ist_clr = (wr & hit_ist) ? pwdata[ST_W-1:0] : 7'h00;
  assign irq = |(ist_q & imask_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Idle status after reset, so no false edge follows it
      status_prev_q <= 7'h25;
      ist_q <= 7'h00;
      imask_q <= chsf_pkg::RST_IRQ_MASK;
    end else begin
      status_prev_q <= status;
      ist_q <= ev | (ist_q & ~ist_clr);
      if (wr & hit_imask) begin
        imask_q <= pwdata[ST_W-1:0];
      end
    end
  end

  // Read data captured in the setup phase
  logic [31:0] rd_mux;

  assign rd_mux = hit_st ? {25'h0, status} :
                  hit_rx ? rx_data_q :
                  hit_ist ? {25'h0, ist_q} :
                  hit_imask ? {25'h0, imask_q} :
                  hit_tx ? tx_hold_q :
                  hit_cmd ? cmd_sr_q : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup) begin
      prdata_q <= rd_mux;
    end
  end

  assign prdata = prdata_q;
endmodule // chsf_top
`default_nettype wire

/* File: include/chsf_pkg.sv */
// Constants shared by the card host status flag logic.
// Assumes a 32-bit APB register bus and a one-bit card data line.
`default_nettype none
package chsf_pkg;
  // Byte addresses of the registers
  localparam logic [31:0] ADDR_CTRL = 32'h4000_0004;
  localparam logic [31:0] ADDR_COMMAND = 32'h4000_0014;
  localparam logic [31:0] ADDR_RECEIVE = 32'h4000_0030;
  localparam logic [31:0] ADDR_TRANSMIT = 32'h4000_0034;
  localparam logic [31:0] ADDR_STATUS = 32'h4000_0040;
  localparam logic [31:0] ADDR_IRQ_STAT = 32'h4000_0044;
  localparam logic [31:0] ADDR_IRQ_MASK = 32'h4000_0048;
  // Status and interrupt bit positions
  localparam int ST_CMD_SENT = 0;
  localparam int ST_RX_READY = 1;
  localparam int ST_TX_MOVED = 2;
  localparam int ST_BLK_END = 3;
  localparam int ST_XFER_ACT = 4;
  localparam int ST_CARD_FREE = 5;
  localparam int ST_CRC_ERR = 6;
  localparam int ST_WIDTH = 7;
  // Control fields
  localparam int CTRL_START = 0;
  localparam int CTRL_WRITE = 1;
  localparam int CTRL_WORDS_LO = 8;
  localparam int CTRL_WORDS_HI = 11;
  // Reset values
  localparam logic RST_CMD_SENT = 1'b1;
  localparam logic RST_TX_MOVED = 1'b1;
  localparam logic [ST_WIDTH-1:0] RST_IRQ_MASK = 7'h00;
  // Link framing
  localparam logic [15:0] CRC16_POLY = 16'h1021;
  localparam logic [5:0] CMD_BITS = 6'h20;
  localparam logic [4:0] WORD_LAST_BIT = 5'h1f;
  localparam logic [3:0] CRC_LAST_BIT = 4'hf;
  localparam logic [4:0] TOKEN_BITS = 5'h04;

  typedef enum logic [3:0] {
    CHSF_IDLE = 4'h0,
    CHSF_TX_START = 4'h1,
    CHSF_TX_DATA = 4'h2,
    CHSF_TX_CRC = 4'h3,
    CHSF_TX_END = 4'h4,
    CHSF_TOK_WAIT = 4'h5,
    CHSF_TOK_BITS = 4'h6,
    CHSF_BUSY = 4'h7,
    CHSF_RX_WAIT = 4'h8,
    CHSF_RX_DATA = 4'h9,
    CHSF_RX_CRC = 4'ha,
    CHSF_RX_CHECK = 4'hb
  } chsf_state_t;
endpackage
`default_nettype wire

/* File: hw/chsf_sync.sv */
// Two-stage synchroniser for a group of levels.
// Assumes inputs from outside the pclk domain.
`default_nettype none
module chsf_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '1;
      q <= '1;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // chsf_sync
`default_nettype wire

/* File: hw/chsf_crc16.sv */
// Serial CRC16 engine, one bit per enabled cycle, MSB first.
// Assumes the caller clears it before each block.
`default_nettype none
module chsf_crc16 (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic en,
  input wire logic bit_in,
  output logic [15:0] crc_q
);
  logic fb;
  logic [15:0] crc_d;

  assign fb = bit_in ^ crc_q[15];
  assign crc_d = {crc_q[14:0], 1'b0} ^ (fb ? chsf_pkg::CRC16_POLY : 16'h0000);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crc_q <= 16'h0000;
    end else if (clear) begin
      crc_q <= 16'h0000;
    end else if (en) begin
      crc_q <= crc_d;
    end
  end
endmodule // chsf_crc16
`default_nettype wire

/* File: sim/chsf_properties.sv */
// Checker of the card host flags, bound to every chsf_top.
// Assumes zero-wait APB with one idle cycle between transfers.
`default_nettype none
module chsf_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic irq,
  input wire logic dat0_i,
  input wire logic cmd_oe,
  input wire logic dat0_oe
);
  logic [5:0] dh_q;
  wire logic acc = psel && penable;
  wire logic rd = acc && !pwrite;
  wire logic wr = acc && pwrite;
  wire logic st_set = psel && !penable && paddr == chsf_pkg::ADDR_STATUS;
  wire logic st_rd = rd && paddr == chsf_pkg::ADDR_STATUS;
  wire logic hit = paddr inside {chsf_pkg::ADDR_CTRL, chsf_pkg::ADDR_COMMAND,
    chsf_pkg::ADDR_RECEIVE, chsf_pkg::ADDR_TRANSMIT, chsf_pkg::ADDR_STATUS,
    chsf_pkg::ADDR_IRQ_STAT, chsf_pkg::ADDR_IRQ_MASK};
  // Recent samples of the data line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) dh_q <= 6'h3f;
    else dh_q <= {dh_q[4:0], dat0_i};
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_err_unmapped: assert property (acc && !hit |-> pslverr)
    else $error("unmapped access not refused");
  a_mask_quiet: assert property (wr && paddr == chsf_pkg::ADDR_IRQ_MASK
    && pwdata[6:0] == 7'h00 |=> !irq [*3]) else $error("irq while all masked");
  a_cmd_clear: assert property (wr && paddr == chsf_pkg::ADDR_COMMAND
    ##2 st_set ##1 st_rd |-> !prdata[0]) else $error("command flag not cleared");
  a_rx_clear: assert property (rd && paddr == chsf_pkg::ADDR_RECEIVE
    ##2 st_set ##1 st_rd |-> !prdata[1]) else $error("receive flag not cleared");
  a_tx_clear: assert property (wr && paddr == chsf_pkg::ADDR_TRANSMIT
    ##2 st_set ##1 st_rd |-> !prdata[2]) else $error("transmit flag not cleared");
  a_blk_clear: assert property (st_rd && prdata[3]
    ##2 st_set ##1 st_rd |-> !prdata[3]) else $error("block end not read-cleared");
  a_free_mirror: assert property (st_rd && ((dh_q == 6'h00 && !dat0_oe) || dh_q == 6'h3f)
    |-> prdata[5] == dh_q[0]) else $error("card free flag wrong");
  a_cmd_busy: assert property (st_set && cmd_oe |=> !prdata[0])
    else $error("command flag high while sending");
endmodule // chsf_properties
bind chsf_top chsf_properties chsf_properties_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pslverr(pslverr), .irq(irq), .dat0_i(dat0_i),
  .cmd_oe(cmd_oe), .dat0_oe(dat0_oe));
`default_nettype wire

/* File: sim/chsf_card.sv */
// Behavioural card: link clock, write token and busy, read block.
// Assumes the host drives dat0 only while dat0_oe is high.
`default_nettype none
module chsf_card #(
  parameter int BUSY_FALLS = 8
) (
  input wire logic run,
  input wire logic rd_go,
  input wire logic [31:0] rd_word,
  input wire logic bad_crc,
  input wire logic host_o,
  input wire logic host_oe,
  output logic card_clk,
  output logic dat0,
  output logic [63:0] got
);
  timeunit 1ns;
  timeprecision 100ps;
  logic drv = 1'b0;
  logic val = 1'b1;
  // Pull-up: an undriven line reads high
  assign dat0 = host_oe ? host_o : (drv ? val : 1'b1);
  initial begin
    card_clk = 1'b0;
    #7;
    forever begin
      wait (run);
      #24 card_clk = 1'b1;
      #24 card_clk = 1'b0;
    end
  end
  task automatic put(input logic b);
    @(negedge card_clk);
    drv = 1'b1;
    val = b;
  endtask
  // CRC16 of one word, MSB first, zero start value
  function automatic logic [15:0] crc_of(input logic [31:0] w);
    logic [15:0] c;
    c = 16'h0000;
    for (int i = 31; i >= 0; i--) begin
      c = (c << 1) ^ ((w[i] ^ c[15]) ? chsf_pkg::CRC16_POLY : 16'h0000);
    end
    return c;
  endfunction
  initial begin
    logic [15:0] cw;
    got = 64'h0;
    forever begin
      @(posedge card_clk);
      if (rd_go) begin
        put(1'b0);
        for (int i = 31; i >= 0; i--) put(rd_word[i]);
        cw = crc_of(rd_word) ^ {15'h0000, bad_crc};
        for (int i = 15; i >= 0; i--) put(cw[i]);
        put(1'b1);
        @(negedge card_clk) drv = 1'b0;
        wait (!rd_go);
      end else if (host_oe && !host_o) begin
        for (int i = 0; i < 64; i++) begin
          @(posedge card_clk);
          got = {got[62:0], dat0};
        end
        while (host_oe) @(posedge card_clk);
        for (int i = 4; i >= 0; i--) put(5'h05 >> i);
        repeat (BUSY_FALLS) put(1'b0);
        @(negedge card_clk) drv = 1'b0;
      end
    end
  end
endmodule // chsf_card
`default_nettype wire

/* File: sim/test_card_host_status_flags.sv */
// Self-checking bench for the card host status flags over APB.
// Assumes zero-wait APB and the card model on the data line.
`default_nettype none
module test_card_host_status_flags;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk, presetn, psel, penable, pwrite, run, rd_go, err, bad;
  logic pready, pslverr, irq, card_clk, cmd_o, cmd_oe, dat0, dat0_o, dat0_oe;
  logic [31:0] paddr, pwdata, prdata, rd_word, r;
  logic [63:0] got;
  int failures, checks;
  logic [31:0] cmd_got = 32'h0;
  always @(posedge card_clk) begin
    if (cmd_oe) begin
      cmd_got <= {cmd_got[30:0], cmd_o};
    end
  end
  chsf_top chsf_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .card_clk(card_clk), .cmd_o(cmd_o), .cmd_oe(cmd_oe),
    .dat0_i(dat0), .dat0_o(dat0_o), .dat0_oe(dat0_oe));
  chsf_card chsf_card_i (.run(run), .rd_go(rd_go), .rd_word(rd_word), .bad_crc(bad),
    .host_o(dat0_o),
    .host_oe(dat0_oe), .card_clk(card_clk), .dat0(dat0), .got(got));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic conclude();
    if (failures == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      failures++;
      conclude();
    end
    @(posedge pclk);
  endtask
  task automatic st();
    apb(1'b0, chsf_pkg::ADDR_STATUS, 32'h0);
  endtask
  task automatic wait_st(input int b, input logic v);
    int n;
    n = 0;
    do begin
      st();
      n++;
    end while (r[b] !== v && n < 2000);
    if (r[b] !== v) begin
      failures++;
      conclude();
    end
  endtask
  initial begin
    {presetn, psel, penable, pwrite, run, rd_go, bad} = 7'h00;
    {paddr, pwdata, rd_word} = 96'h0;
    failures = 0;
    checks = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    st();
    chk(r & 32'h3f, 32'h25);
    apb(1'b0, chsf_pkg::ADDR_IRQ_MASK, 32'h0);
    chk(r, 32'h0);
    apb(1'b0, 32'h4000_0080, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, chsf_pkg::ADDR_IRQ_MASK, 32'h08);
    // Command stays in progress while the link clock stands still
    apb(1'b1, chsf_pkg::ADDR_COMMAND, 32'h4a5a_0f01);
    st();
    chk(r & 32'h1, 32'h0);
    run <= 1'b1;
    wait_st(chsf_pkg::ST_CMD_SENT, 1'b1);
    chk(cmd_got, 32'h4a5a_0f01);
    run <= 1'b0;
    apb(1'b0, chsf_pkg::ADDR_IRQ_STAT, 32'h0);
    chk(r & 32'h1, 32'h1);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, chsf_pkg::ADDR_IRQ_STAT, 32'h7f);
    apb(1'b0, chsf_pkg::ADDR_IRQ_STAT, 32'h0);
    chk(r & 32'h7f, 32'h0);
    // Two-word block write
    apb(1'b1, chsf_pkg::ADDR_TRANSMIT, 32'hc3a5_1e69);
    st();
    chk(r & 32'h4, 32'h0);
    apb(1'b1, chsf_pkg::ADDR_CTRL, 32'h0000_0103);
    run <= 1'b1;
    wait_st(chsf_pkg::ST_TX_MOVED, 1'b1);
    chk(r & 32'h10, 32'h10);
    apb(1'b1, chsf_pkg::ADDR_TRANSMIT, 32'h5a0f_96e1);
    wait_st(chsf_pkg::ST_XFER_ACT, 1'b0);
    chk(got[63:32], 32'hc3a5_1e69);
    chk(got[31:0], 32'h5a0f_96e1);
    wait_st(chsf_pkg::ST_BLK_END, 1'b1);
    chk({31'h0, irq}, 32'h1);
    st();
    chk(r & 32'h8, 32'h0);
    wait_st(chsf_pkg::ST_CARD_FREE, 1'b0);
    wait_st(chsf_pkg::ST_CARD_FREE, 1'b1);
    apb(1'b1, chsf_pkg::ADDR_IRQ_STAT, 32'h08);
    chk({31'h0, irq}, 32'h0);
    // One-word block read
    apb(1'b1, chsf_pkg::ADDR_CTRL, 32'h0000_0001);
    rd_word <= 32'h96c3_5a7e;
    rd_go <= 1'b1;
    wait_st(chsf_pkg::ST_RX_READY, 1'b1);
    chk(r & 32'h10, 32'h10);
    wait_st(chsf_pkg::ST_XFER_ACT, 1'b0);
    chk(r & 32'h48, 32'h0);
    apb(1'b0, chsf_pkg::ADDR_RECEIVE, 32'h0);
    chk(r, 32'h96c3_5a7e);
    st();
    chk(r & 32'h2, 32'h0);
    // Same read with a corrupted CRC16
    rd_go <= 1'b0;
    bad <= 1'b1;
    apb(1'b1, chsf_pkg::ADDR_CTRL, 32'h0000_0001);
    rd_go <= 1'b1;
    wait_st(chsf_pkg::ST_RX_READY, 1'b1);
    wait_st(chsf_pkg::ST_XFER_ACT, 1'b0);
    chk(r & 32'h48, 32'h40);
    st();
    chk(r & 32'h40, 32'h0);
    rd_go <= 1'b0;
    run <= 1'b0;
    apb(1'b1, chsf_pkg::ADDR_IRQ_MASK, 32'h0);
    conclude();
  end
endmodule // test_card_host_status_flags
`default_nettype wire
